// *** rtl/dual_core_interrupt_router.sv ***
// two-core interrupt router: source routing, OR merge, nmi masking,
// raw state readback and an event interrupt
// assumes sources and nmi mask inputs are synchronous to clk
// Functional notes
// - each core gets 32 lines, 26 of them drivable peripheral lines.
// - only lines 0-5, 8-10, 12-14, 17-28, 30-31 may carry sources.
// - lines 6, 7, 11, 15, 16 and 29 never carry any source.
// - each source has one route setting per core.
// - a route holding a peripheral line drives that line.
// - a route holding any internal line cuts the source off alike.
// - sources sharing one line are ORed onto it.
// - while a core's nmi mask input is high its line 14 sources drop.
// - each source's raw level is readable in a per-core state word.
// - source n sits at bit n mod 32 of state word n div 32.
// - lines 10, 22, 28, 30 are edge, 14 is nmi, the rest level.
// - each line carries a fixed priority level published as a port.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module dual_core_interrupt_router
   import irq_route_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [NUM_SRC-1:0] src_irq,
   input wire logic protocol_core_nmi_mask,
   input wire logic application_core_nmi_mask,
   input wire irq_route_pkg::reg_req_t req,
   output logic [31:0] rdata,
   output logic [31:0] protocol_core_irq,
   output logic [31:0] application_core_irq,
   output logic [31:0] line_edge_type,
   output logic [95:0] line_priority,
   output logic [4:0] nmi_line,
   output logic irq
);
   import irq_route_pkg::*;

   route_state_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////
   // decode a route value to a one-hot line, internal numbers give zero
   function automatic logic [31:0] line_hot(input logic [4:0] r);
      logic [31:0] h;
      h = 32'h0000_0001 << r;
      line_hot = h & PERIPH_LINES;
   endfunction : line_hot

   // merge all routes of one core into its 32 lines
   function automatic logic [31:0] merge(
      input logic [NUM_SRC-1:0][ROUTE_W-1:0] rt,
      input logic [NUM_SRC-1:0] src,
      input logic nmi_mask);
      logic [31:0] acc;
      logic [31:0] hot;
      acc = 32'h0000_0000;
      hot = 32'h0000_0000;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         hot = line_hot(rt[i]);
         if (nmi_mask && rt[i] == NMI_LINE)
         begin
            hot = 32'h0000_0000;
         end
         if (src[i])
         begin
            acc = acc | hot;
         end
      end
      merge = acc;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////
   // line outputs stay combinational so masking lifts at once
   assign protocol_core_irq = merge(s_q.route0, src_irq,
      protocol_core_nmi_mask);
   assign application_core_irq = merge(s_q.route1, src_irq,
      application_core_nmi_mask);
   assign line_edge_type = EDGE_LINES;
   assign nmi_line = NMI_LINE;
   assign line_priority = LINE_PRIO;
   assign rdata = s_q.rdata;
   assign irq = |(s_q.stat & s_q.mask);

   ////////////////////////////////////////////////////////////////////
   // register port, events and readback
   always_comb
   begin
      logic [NUM_SRC-1:0] rise;
      logic [31:0] ev;
      logic [31:0] wide;
      logic [11:0] off;
      int idx;
      rise = src_irq & ~s_q.src_prev;
      ev = 32'h0000_0000;
      wide = 32'h0000_0000;
      off = 12'h000;
      idx = 0;
      s_d = s_q;
      s_d.src_prev = src_irq;
      s_d.rdata = 32'h0000_0000;
      // route writes, one word per source and core
      if (req.wr)
      begin
         if (req.addr >= ROUTE0_BASE && req.addr < ROUTE1_BASE)
         begin
            off = req.addr - ROUTE0_BASE;
            idx = int'(off[11:2]);
            if (idx < NUM_SRC)
            begin
               s_d.route0[idx] = req.wdata[4:0];
            end
         end
         else if (req.addr >= ROUTE1_BASE && req.addr < STATE0_BASE)
         begin
            off = req.addr - ROUTE1_BASE;
            idx = int'(off[11:2]);
            if (idx < NUM_SRC)
            begin
               s_d.route1[idx] = req.wdata[4:0];
            end
         end
         else if (req.addr == IRQ_MASK_ADDR)
         begin
            s_d.mask = req.wdata;
         end
         else if (req.addr == IRQ_STAT_ADDR)
         begin
            s_d.stat = s_q.stat & ~req.wdata;
         end
      end
      // rising edge of any source in word w sets status bit w
      for (int i = 0; i < NUM_SRC; i++)
      begin
         ev[i / 32] = ev[i / 32] | rise[i];
      end
      s_d.stat = s_d.stat | ev; // set wins over clear
      // reads, answered in the next cycle
      if (req.rd)
      begin
         if (req.addr >= ROUTE0_BASE && req.addr < ROUTE1_BASE)
         begin
            off = req.addr - ROUTE0_BASE;
            idx = int'(off[11:2]);
            if (idx < NUM_SRC)
            begin
               s_d.rdata = {27'h0000000, s_q.route0[idx]};
            end
         end
         else if (req.addr >= ROUTE1_BASE && req.addr < STATE0_BASE)
         begin
            off = req.addr - ROUTE1_BASE;
            idx = int'(off[11:2]);
            if (idx < NUM_SRC)
            begin
               s_d.rdata = {27'h0000000, s_q.route1[idx]};
            end
         end
         else if ((req.addr >= STATE0_BASE &&
                   req.addr < STATE0_BASE + 12'(WORDS * 4)) ||
                  (req.addr >= STATE1_BASE &&
                   req.addr < STATE1_BASE + 12'(WORDS * 4)))
         begin
            // both cores see the same raw levels
            off = (req.addr >= STATE1_BASE) ? req.addr - STATE1_BASE
                                            : req.addr - STATE0_BASE;
            idx = int'(off[11:2]);
            for (int b = 0; b < 32; b++)
            begin
               if (idx * 32 + b < NUM_SRC)
               begin
                  wide[b] = src_irq[idx * 32 + b];
               end
            end
            s_d.rdata = wide;
         end
         else if (req.addr == IRQ_STAT_ADDR)
         begin
            s_d.rdata = s_q.stat;
         end
         else if (req.addr == IRQ_MASK_ADDR)
         begin
            s_d.rdata = s_q.mask;
         end
      end
   end

   // one state register; routes start on an internal line
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NUM_SRC; i++)
         begin
            s_q.route0[i] <= ROUTE_RST;
            s_q.route1[i] <= ROUTE_RST;
         end
         s_q.src_prev <= '0;
         s_q.stat <= 32'h0000_0000;
         s_q.mask <= IRQ_MASK_RST;
         s_q.rdata <= 32'h0000_0000;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule : dual_core_interrupt_router
`default_nettype wire

// *** rtl/irq_route_pkg.sv ***
// constants and carriers of the two-core interrupt router
// assumes one 40 MHz clock domain shared with the register port
package irq_route_pkg;
   localparam int NUM_SRC = 69;
   localparam int NUM_LINE = 32;
   localparam int ROUTE_W = 5;
   localparam int WORDS = (NUM_SRC + 31) / 32;
   // peripheral lines a source may drive
   localparam logic [31:0] PERIPH_LINES = 32'hDFFE773F;
   localparam logic [31:0] EDGE_LINES = 32'h50400400;
   localparam logic [4:0] NMI_LINE = 5'h0E;
   // fixed priority per line, three bits, line 0 in the low bits
   // nmi line 14 reads 7, above every maskable level
   localparam logic [95:0] LINE_PRIO = 96'hB1C7_646D_244D_7C96_4924_9249;
   // route reset value: an internal line, so every source starts cut off
   localparam logic [4:0] ROUTE_RST = 5'h06;
   // register map: word index = byte address / 4
   localparam logic [11:0] ROUTE0_BASE = 12'h000;
   localparam logic [11:0] ROUTE1_BASE = 12'h200;
   localparam logic [11:0] STATE0_BASE = 12'h400;
   localparam logic [11:0] STATE1_BASE = 12'h420;
   localparam logic [11:0] IRQ_STAT_ADDR = 12'h440;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h444;
   localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [NUM_SRC-1:0][ROUTE_W-1:0] route0;
      logic [NUM_SRC-1:0][ROUTE_W-1:0] route1;
      logic [NUM_SRC-1:0] src_prev;
      logic [31:0] stat;
      logic [31:0] mask;
      logic [31:0] rdata;
   } route_state_t;
endpackage : irq_route_pkg

// *** tb/router_checker.sv ***
// port checker of the two-core interrupt router
// assumes one clk domain; bound onto the router top below
`timescale 1ns/1ps
`default_nettype none
module router_checker
   import irq_route_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [NUM_SRC-1:0] src_irq,
   input wire logic protocol_core_nmi_mask,
   input wire logic application_core_nmi_mask,
   input wire irq_route_pkg::reg_req_t req,
   input wire logic [31:0] rdata,
   input wire logic [31:0] protocol_core_irq,
   input wire logic [31:0] application_core_irq,
   input wire logic [31:0] line_edge_type,
   input wire logic [95:0] line_priority,
   input wire logic [4:0] nmi_line
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // line and readback relations
   AST_NO_INTERNAL: assert property (
      ((protocol_core_irq | application_core_irq) & ~PERIPH_LINES) == 0)
      else $error("source seen on an internal line");
   AST_RD_IDLE: assert property (!$past(req.rd) |-> rdata == 0)
      else $error("read data outside the read cycle");
   AST_STATE_W0: assert property (req.rd && req.addr == STATE0_BASE
      |=> rdata == $past(src_irq[31:0])) else $error("state word 0 wrong");
   AST_STATE_W2: assert property (req.rd && req.addr == 12'h428
      |=> rdata == {27'h0, $past(src_irq[68:64])})
      else $error("state word 2 wrong");
   AST_ROUTE: assert property (req.wr && req.addr == ROUTE0_BASE
      && req.wdata[4:0] == 5'h03 ##1 src_irq[0] |-> protocol_core_irq[3])
      else $error("routed source missing on its line");
   AST_NMI0: assert property (protocol_core_nmi_mask
      |-> !protocol_core_irq[14]) else $error("nmi line not masked, core 0");
   AST_NMI1: assert property (application_core_nmi_mask
      |-> !application_core_irq[14]) else $error("nmi line not masked, core 1");
   AST_ALL_OFF: assert property (src_irq == '0
      |-> (protocol_core_irq | application_core_irq) == 0)
      else $error("line high with no source high");
   AST_LINE_KIND: assert property (
      line_edge_type == 32'h50400400 && nmi_line == 5'h0E)
      else $error("line kinds wrong");
   AST_PRIO: assert property (
      line_priority == 96'hB1C7_646D_244D_7C96_4924_9249)
      else $error("line priorities wrong");
   cover property (protocol_core_nmi_mask && src_irq != '0);
   cover property (req.rd ##1 rdata != 0);
   cover property (req.wr && req.addr == IRQ_STAT_ADDR);
endmodule : router_checker
bind dual_core_interrupt_router router_checker u_router_checker (
   .clk(clk), .sys_rst(sys_rst), .src_irq(src_irq), .req(req),
   .protocol_core_nmi_mask(protocol_core_nmi_mask), .rdata(rdata),
   .application_core_nmi_mask(application_core_nmi_mask),
   .protocol_core_irq(protocol_core_irq), .nmi_line(nmi_line),
   .application_core_irq(application_core_irq),
   .line_edge_type(line_edge_type), .line_priority(line_priority));
`default_nettype wire

// *** tb/core_irq_sink.sv ***
// far-side model: two cores sampling their interrupt lines
// assumes lines are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module core_irq_sink
(
   input wire logic clk,
   input wire logic [31:0] lines0,
   input wire logic [31:0] lines1,
   output logic [31:0] seen0,
   output logic [31:0] seen1
);
   // cores latch lines each edge, so glitches between edges go unseen
   always_ff @(posedge clk)
   begin
      seen0 <= lines0;
      seen1 <= lines1;
   end
endmodule : core_irq_sink
`default_nettype wire

// *** tb/dual_core_interrupt_router_tb.sv ***
// bench of the two-core interrupt router
// assumes the router, its package and the core model are compiled first
`timescale 1ns/1ps
`default_nettype none
module dual_core_interrupt_router_tb;
   import irq_route_pkg::*;
   logic clk = 0, sys_rst = 1, nmi0 = 0, nmi1 = 0, irq;
   logic [NUM_SRC-1:0] src_irq = '0;
   reg_req_t req = '0;
   logic [31:0] rdata, irq0, irq1, seen0, seen1;
   int n_errors = 0, n_checks = 0, cycles = 0;
   always #12.5 clk = ~clk;
   dual_core_interrupt_router u_dual_core_interrupt_router (.clk(clk),
      .sys_rst(sys_rst), .src_irq(src_irq), .protocol_core_nmi_mask(nmi0),
      .application_core_nmi_mask(nmi1), .req(req), .rdata(rdata),
      .protocol_core_irq(irq0), .application_core_irq(irq1),
      .line_edge_type(), .line_priority(), .nmi_line(), .irq(irq));
   core_irq_sink u_core_irq_sink (.clk(clk), .lines0(irq0), .lines1(irq1),
      .seen0(seen0), .seen1(seen1));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd
   task automatic settle;
      @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic route_or;
      @(posedge clk);
      src_irq <= 69'h21;
      wr(ROUTE0_BASE, 32'h3);
      wr(ROUTE0_BASE + 12'h014, 32'h3);
      wr(ROUTE1_BASE, 32'h1F);
      settle();
      chk(seen0, 32'h8);
      chk(seen1, 32'h80000000);
      @(posedge clk);
      src_irq <= 69'h20;
      settle();
      chk(seen0 | seen1, 32'h8);
   endtask : route_or
   task automatic cut_off;
      logic [4:0] off [6] = '{5'h06, 5'h07, 5'h0B, 5'h0F, 5'h10, 5'h1D};
      @(posedge clk);
      src_irq <= 69'h1;
      foreach (off[i])
      begin
         wr(ROUTE0_BASE, {27'h0, off[i]});
         wr(ROUTE1_BASE, {27'h0, off[i]});
         settle();
         chk(seen0 | seen1, 32'h0);
      end
   endtask : cut_off
   task automatic nmi_hold;
      wr(ROUTE0_BASE + 12'h004, 32'hE);
      wr(ROUTE1_BASE + 12'h004, 32'hE);
      src_irq <= 69'h2;
      nmi0 <= 1'b1;
      settle();
      chk(seen0, 32'h0);
      chk(seen1, 32'h4000);
      @(posedge clk);
      nmi0 <= 1'b0;
      nmi1 <= 1'b1;
      settle();
      chk(seen0, 32'h4000);
      chk(seen1, 32'h0);
   endtask : nmi_hold
   // sources 0, 54, 68; only word 1 events are unmasked
   task automatic state_event;
      wr(IRQ_MASK_ADDR, 32'h2);
      src_irq <= 69'h10_0040_0000_0000_0001;
      rd(STATE0_BASE, 32'h1);
      rd(STATE1_BASE + 12'h004, 32'h00400000);
      rd(STATE1_BASE + 12'h008, 32'h10);
      rd(12'h800, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wr(IRQ_STAT_ADDR, 32'h2);
      settle();
      chk({31'h0, irq}, 32'h0);
      rd(IRQ_STAT_ADDR, 32'h5);
   endtask : state_event
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // hang guard, far above the roughly 70 cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(ROUTE0_BASE, 32'h6);
      route_or();
      cut_off();
      nmi_hold();
      state_event();
      give_verdict();
   end
endmodule : dual_core_interrupt_router_tb
`default_nettype wire
